// file: flag_check_pkg.sv
package flag_check_pkg;
  // apb register offsets
  localparam logic [7:0] OFF_ID = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_FAULT_ADDR = 8'h10;
  localparam logic [7:0] OFF_FAULT_INFO = 8'h14;
  // capability encodings for the id field
  localparam logic [1:0] CAP_NONE = 2'h0;
  localparam logic [1:0] CAP_ACCESS = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;
  // descriptor bit positions
  localparam int DESC_ACCESS_FLAG = 10;
  localparam int DESC_AP2 = 7;
  localparam int DESC_S2AP1 = 7;
  localparam int DESC_DIRTY_MOD = 51;
  // ctrl bit positions
  localparam int CTRL_AFD_S1 = 0;
  localparam int CTRL_AFD_S2 = 1;
  // status bit positions
  localparam int ST_ACCESS = 0;
  localparam int ST_PERM = 1;
  localparam int ST_UPDATE = 2;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // check result codes
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_ACCESS = 2'h1;
  localparam logic [1:0] RES_PERM = 2'h2;
endpackage : flag_check_pkg

// file: access_dirty_flag_checker.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1 - id field reports none, access, or both updates
// R2 - per-stage enables gate hardware flag updates
// R3 - descriptor updates are atomic read-modify-write
// R4 - software keeps shared descriptor enables identical
// R5 - access flag zero raises access fault
// R6 - faulting descriptors are never cached here
// R7 - setting access flag needs no invalidation
// R8 - access fault reported before permission fault
// R9 - fault disable treats access flag as one
// R10 - write without permission raises permission fault
// R11 - clean becomes dirty, dirty stays, readonly errors
// R12 - faults are recorded for driver software
// R13 - driver fixes flags then resumes transactions
// R14 - pinned mappings preset flags, terminate model
// R15 - software updates use modifier convention atomically
// R16 - enabled update sets access flag, never clears
// R17 - bit 51 is the dirty-bit-modifier
// R18 - modifier one makes clean page writable
// R19 - updates disabled means no descriptor writes
module access_dirty_flag_checker #(
  parameter logic [1:0] HW_CAP = flag_check_pkg::CAP_BOTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // descriptor check request from the walker
  input wire logic chk_valid_i,
  input wire logic [63:0] chk_desc_i,
  input wire logic [31:0] chk_addr_i,
  input wire logic chk_write_i,
  input wire logic chk_stage2_i,
  input wire logic chk_access_update_enable_i,
  input wire logic chk_dirty_update_enable_i,
  // result
  output logic res_valid_o,
  output logic [1:0] res_code_o,
  output logic res_cacheable_o,
  // atomic descriptor write-back
  output logic upd_valid_o,
  output logic [63:0] upd_old_o,
  output logic [63:0] upd_new_o,
  output logic irq_o
);
  import flag_check_pkg::*;

  logic [31:0] ctrl_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [31:0] fault_addr_reg;
  logic [3:0] fault_info_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic res_valid_reg;
  logic [1:0] res_code_reg;
  logic res_cacheable_reg;
  logic upd_valid_reg;
  logic [63:0] upd_old_reg;
  logic [63:0] upd_new_reg;
  logic irq_reg;

  // capability decode
  wire cap_access = (HW_CAP == CAP_ACCESS) || (HW_CAP == CAP_BOTH); // R1
  wire cap_dirty = (HW_CAP == CAP_BOTH); // R1
  wire ha_on = cap_access && chk_access_update_enable_i; // R2 R19
  wire hd_on = cap_dirty && chk_dirty_update_enable_i; // R2 R19

  // descriptor field decode
  wire af = chk_desc_i[DESC_ACCESS_FLAG];
  wire dirty_bit_modifier = chk_desc_i[DESC_DIRTY_MOD]; // R17
  wire writable = chk_stage2_i ? chk_desc_i[DESC_S2AP1] : !chk_desc_i[DESC_AP2];
  wire afd = chk_stage2_i ? ctrl_reg[CTRL_AFD_S2] : ctrl_reg[CTRL_AFD_S1];

  // access check first, permission second
  wire af_missing = !af && !afd; // R9
  wire access_fault = af_missing && !ha_on; // R5
  wire set_af = af_missing && ha_on; // R16
  wire need_write = chk_write_i && !writable;
  wire make_dirty = need_write && dirty_bit_modifier && hd_on; // R18 R11
  wire perm_fault = need_write && !make_dirty; // R10 R11
  wire [1:0] code_next = access_fault ? RES_ACCESS : (perm_fault ? RES_PERM : RES_OK); // R8
  wire do_update = !access_fault && !perm_fault && (set_af || make_dirty); // R19

  // new descriptor: set access flag, grant write; never clear either
  logic [63:0] desc_new;
  always_comb begin
    desc_new = chk_desc_i;
    if (set_af || make_dirty) begin
      desc_new[DESC_ACCESS_FLAG] = 1'b1; // R16
    end
    if (make_dirty) begin
      if (chk_stage2_i) begin
        desc_new[DESC_S2AP1] = 1'b1; // R18
      end else begin
        desc_new[DESC_AP2] = 1'b0; // R18
      end
    end
  end

  // check result and write-back outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_valid_reg <= 1'b0;
      res_code_reg <= RES_OK;
      res_cacheable_reg <= 1'b0;
      upd_valid_reg <= 1'b0;
      upd_old_reg <= 64'h0;
      upd_new_reg <= 64'h0;
    end else begin
      res_valid_reg <= chk_valid_i;
      res_code_reg <= code_next;
      res_cacheable_reg <= chk_valid_i && (code_next == RES_OK); // R6 R7
      upd_valid_reg <= chk_valid_i && do_update; // R3
      upd_old_reg <= chk_desc_i; // R3
      upd_new_reg <= desc_new;
    end
  end

  // apb decode
  wire apb_acc = psel_i && penable_i && !pready_reg;
  wire apb_wr = apb_acc && pwrite_i;
  wire hit_ctrl = paddr_i == OFF_CTRL;
  wire hit_status = paddr_i == OFF_STATUS;
  wire hit_mask = paddr_i == OFF_MASK;
  wire mapped = hit_ctrl || hit_status || hit_mask || paddr_i == OFF_ID ||
    paddr_i == OFF_FAULT_ADDR || paddr_i == OFF_FAULT_INFO;
  wire [31:0] rd_mux =
    (paddr_i == OFF_ID) ? {30'h0, HW_CAP} :
    hit_ctrl ? ctrl_reg :
    hit_status ? {29'h0, status_reg} :
    hit_mask ? {29'h0, mask_reg} :
    (paddr_i == OFF_FAULT_ADDR) ? fault_addr_reg :
    (paddr_i == OFF_FAULT_INFO) ? {28'h0, fault_info_reg} : 32'h0;
  wire fault_ev = chk_valid_i && (code_next != RES_OK);
  wire [2:0] events = {chk_valid_i && do_update,
    chk_valid_i && code_next == RES_PERM, chk_valid_i && code_next == RES_ACCESS};
  wire [2:0] w1c = (apb_wr && hit_status) ? pwdata_i[2:0] : 3'h0;

  // apb answer, one wait state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= apb_acc;
      pslverr_reg <= apb_acc && !mapped;
      prdata_reg <= apb_acc ? rd_mux : 32'h0;
    end
  end

  // control, mask, sticky status (set wins), fault record
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
      status_reg <= 3'h0;
      fault_addr_reg <= 32'h0;
      fault_info_reg <= 4'h0;
      irq_reg <= 1'b0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        ctrl_reg <= {30'h0, pwdata_i[1:0]};
      end
      if (apb_wr && hit_mask) begin
        mask_reg <= pwdata_i[2:0];
      end
      status_reg <= (status_reg & ~w1c) | events; // R12
      if (fault_ev) begin
        fault_addr_reg <= chk_addr_i; // R12
        fault_info_reg <= {chk_stage2_i, chk_write_i, code_next}; // R12
      end
      irq_reg <= |(((status_reg & ~w1c) | events) & mask_reg);
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign res_valid_o = res_valid_reg;
  assign res_code_o = res_code_reg;
  assign res_cacheable_o = res_cacheable_reg;
  assign upd_valid_o = upd_valid_reg;
  assign upd_old_o = upd_old_reg;
  assign upd_new_o = upd_new_reg;
  assign irq_o = irq_reg;

  // assertions
  a_access_fault_seen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
    chk_valid_i && !af && !afd && !ha_on |=> res_code_o == RES_ACCESS)
    else $error("missing access fault");
  a_access_before_perm: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
    chk_valid_i && access_fault && perm_fault |=> res_code_o == RES_ACCESS)
    else $error("permission fault reported before access fault");
  a_afd_no_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
    chk_valid_i && afd |=> res_code_o != RES_ACCESS)
    else $error("access fault despite disable");
  a_perm_fault_seen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
    chk_valid_i && af && chk_write_i && !writable && !dirty_bit_modifier |=> res_code_o == RES_PERM)
    else $error("missing permission fault");
  a_no_cache_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
    res_valid_o && res_code_o != RES_OK |-> !res_cacheable_o)
    else $error("faulting descriptor marked cacheable");
  a_af_never_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R16
    upd_valid_o |-> upd_new_o[DESC_ACCESS_FLAG] &&
    upd_new_o[DESC_DIRTY_MOD] == upd_old_o[DESC_DIRTY_MOD])
    else $error("update cleared access flag or changed modifier");
  a_no_write_disabled: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R19
    chk_valid_i && !chk_access_update_enable_i && !chk_dirty_update_enable_i |=> !upd_valid_o)
    else $error("descriptor written with updates disabled");
  a_dirty_needs_dbm: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R18
    chk_valid_i && make_dirty && af |=> upd_valid_o && res_code_o == RES_OK)
    else $error("clean page not made writable");
  a_irq_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
    fault_ev && mask_reg[ST_ACCESS] && code_next == RES_ACCESS |=> irq_o)
    else $error("interrupt not raised");

  // capability field and per-stage gating
  a_id_field_value: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
    psel_i && penable_i && !pready_o && !pwrite_i && paddr_i == OFF_ID
    |=> prdata_o[1:0] == HW_CAP && prdata_o[31:2] == 30'h0)
    else $error("id field wrong");
  a_dirty_gate_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
    chk_valid_i && !chk_dirty_update_enable_i && chk_write_i && !writable
    |=> res_code_o != RES_OK && !upd_valid_o)
    else $error("dirty update without enable");
  a_set_af_update: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R16
    chk_valid_i && !af && !afd && ha_on
    |=> upd_valid_o || res_code_o == RES_PERM)
    else $error("access flag not set by hardware");

  // atomic write-back pairs with a clean result
  a_update_with_ok: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    upd_valid_o
    |-> res_valid_o && res_code_o == RES_OK)
    else $error("update without ok result");
  a_update_old_match: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    chk_valid_i && do_update
    |=> upd_old_o == $past(chk_desc_i))
    else $error("compare value is not the fetched descriptor");
  a_ok_is_cacheable: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
    res_valid_o && res_code_o == RES_OK
    |-> res_cacheable_o)
    else $error("good translation not cacheable");
  a_no_dbm_no_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R17
    upd_valid_o && !upd_old_o[DESC_DIRTY_MOD]
    |-> upd_new_o[DESC_AP2] == upd_old_o[DESC_AP2])
    else $error("permission changed without modifier");

  // dirty page writes and read-only errors
  a_dirty_stays: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    chk_valid_i && chk_write_i && writable && (af || afd)
    |=> res_code_o == RES_OK && !upd_valid_o)
    else $error("dirty page changed state");
  a_readonly_error: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    chk_valid_i && chk_write_i && !writable && !dirty_bit_modifier && (af || afd)
    |=> res_code_o == RES_PERM && !upd_valid_o)
    else $error("read-only write not an error");

  // fault record, status and interrupt
  a_result_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
    chk_valid_i
    |=> res_valid_o)
    else $error("no result for check");
  a_fault_recorded: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
    fault_ev
    |=> fault_addr_reg == $past(chk_addr_i) && (status_reg[ST_ACCESS] || status_reg[ST_PERM]))
    else $error("fault not recorded");
  a_status_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
    status_reg[ST_ACCESS] && !w1c[ST_ACCESS]
    |=> status_reg[ST_ACCESS])
    else $error("status bit lost");
  a_mask_blocks_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (status_reg & mask_reg) == 3'h0 && (events & mask_reg) == 3'h0
    |=> !irq_o)
    else $error("interrupt while masked");

  // apb answer timing
  a_apb_one_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    psel_i && penable_i && !pready_o
    |=> pready_o)
    else $error("apb answer late");
  a_slverr_with_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pslverr_o
    |-> pready_o)
    else $error("error without ready");
  a_ctrl_write_lands: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    apb_wr && hit_ctrl
    |=> ctrl_reg[1:0] == $past(pwdata_i[1:0]))
    else $error("ctrl write lost");
  c_access_fault: cover property (@(posedge clk_i) disable iff (!rst_n_i) res_code_o == RES_ACCESS);
  c_perm_fault: cover property (@(posedge clk_i) disable iff (!rst_n_i) res_code_o == RES_PERM);
  c_hw_update: cover property (@(posedge clk_i) disable iff (!rst_n_i) upd_valid_o);
  c_dirty_update: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    upd_valid_o && upd_old_o[DESC_DIRTY_MOD]);
  c_irq_raised: cover property (@(posedge clk_i) disable iff (!rst_n_i) irq_o);
endmodule : access_dirty_flag_checker
`default_nettype wire

// file: desc_table_model.sv
`timescale 1ns/10ps
`default_nettype none
module desc_table_model (
  input wire logic clk_i,
  input wire logic [1:0] idx_i,
  output logic [63:0] desc_o,
  input wire logic upd_valid_i,
  input wire logic [63:0] upd_old_i,
  input wire logic [63:0] upd_new_i
);
  logic [63:0] mem [4];
  // descriptor fetch path
  assign desc_o = mem[idx_i];
  // compare-and-swap, a stale old value leaves memory alone
  always @(posedge clk_i) begin
    if (upd_valid_i === 1'b1) begin
      for (int k = 0; k < 4; k++) begin
        if (mem[k] === upd_old_i) mem[k] <= upd_new_i;
      end
    end
  end
endmodule : desc_table_model
`default_nettype wire

// file: test_access_dirty_flag_checker.sv
`timescale 1ns/10ps
`default_nettype none
module test_access_dirty_flag_checker;
  import flag_check_pkg::*;
  localparam logic [1:0] HW_CAP = CAP_BOTH;
  typedef struct packed {logic [1:0] code; logic upd; logic [63:0] nw; logic [63:0] od;} note_t;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, cv = 0, cw = 0, cs2 = 0, ha = 0, hd = 0;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, ca = 0, prd, rd, last_addr = 0;
  logic prdy, perr, rv, cach, uv, irq;
  logic [1:0] rc, idx = 0, afd = 0;
  logic [63:0] uo, un, dsc, cd = 0;
  logic [2:0] seen = 0;
  logic [6:0] r;
  note_t q[$];
  note_t nt;
  int err_count = 0, n_compared = 0;
  access_dirty_flag_checker #(.HW_CAP(HW_CAP)) i_access_dirty_flag_checker (.clk_i(clk),
    .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .chk_valid_i(cv),
    .chk_desc_i(cd), .chk_addr_i(ca), .chk_write_i(cw), .chk_stage2_i(cs2),
    .chk_access_update_enable_i(ha), .chk_dirty_update_enable_i(hd), .res_valid_o(rv),
    .res_code_o(rc), .res_cacheable_o(cach), .upd_valid_o(uv), .upd_old_o(uo),
    .upd_new_o(un), .irq_o(irq));
  desc_table_model i_desc_table_model (.clk_i(clk), .idx_i(idx), .desc_o(dsc),
    .upd_valid_i(uv), .upd_old_i(uo), .upd_new_i(un));
  // clock
  initial forever #4 clk = ~clk;
  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // one apb transfer, bounded wait on pready
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 10);
    if (n >= 10) begin
      err_count++;
      give_verdict();
    end
    rd = prd;
    chk("slverr", perr, a > OFF_FAULT_INFO);
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask : apb
  // expected outcome of one descriptor check
  function automatic note_t expect_of(logic [63:0] d, logic w, logic s2, logic ae, logic de,
                                      logic fd);
    note_t n;
    logic wok, fix;
    wok = s2 ? d[DESC_S2AP1] : !d[DESC_AP2];
    fix = d[DESC_DIRTY_MOD] && de && HW_CAP == CAP_BOTH;
    n.nw = d;
    n.od = d;
    n.upd = 0;
    if (!d[DESC_ACCESS_FLAG] && !fd && !(ae && HW_CAP != CAP_NONE)) n.code = RES_ACCESS;
    else if (w && !wok && !fix) n.code = RES_PERM;
    else begin
      n.code = RES_OK;
      n.upd = (!d[DESC_ACCESS_FLAG] && !fd) || (w && !wok);
      n.nw[DESC_ACCESS_FLAG] = d[DESC_ACCESS_FLAG] | n.upd;
      if (w && !wok) n.nw[DESC_AP2] = s2;
    end
    return n;
  endfunction : expect_of
  // result watcher takes the oldest note
  always @(posedge clk) begin
    if (rst_n && rv === 1'b1) begin
      if (q.size() == 0) chk("spare result", 1, 0);
      else begin
        nt = q.pop_front();
        chk("code", rc, nt.code);
        chk("cacheable", cach, nt.code == RES_OK);
        chk("update", uv, nt.upd);
        if (nt.upd) chk("new desc", un, nt.nw);
        if (nt.upd) chk("old desc", uo, nt.od);
      end
    end
  end
  initial begin
    void'($urandom(32'h7613aecb));
    for (int k = 0; k < 4; k++) i_desc_table_model.mem[k] = {$urandom, $urandom};
    repeat (20) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, OFF_CTRL, 0);
    chk("ctrl reset", rd, CTRL_RESET);
    apb(0, OFF_MASK, 0);
    chk("mask reset", rd[2:0], MASK_RESET);
    apb(1, OFF_ID, 0);
    apb(0, OFF_ID, 0);
    chk("id", rd[1:0], HW_CAP);
    for (int ph = 0; ph < 4; ph++) begin
      apb(1, OFF_CTRL, 32'(ph));
      afd = 2'(ph);
      repeat (100) begin
        r = 7'($urandom);
        cv <= r[6] | r[5];
        cd <= dsc;
        ca <= $urandom;
        {cw, cs2, ha, hd} <= r[3:0];
        if (r[6] | r[5]) begin
          nt = expect_of(dsc, r[3], r[2], r[1], r[0], r[2] ? afd[1] : afd[0]);
          q.push_back(nt);
          seen |= {nt.upd, nt.code == RES_PERM, nt.code == RES_ACCESS};
        end
        if (uv !== 1'b1 && r[4]) i_desc_table_model.mem[idx] <= {$urandom, $urandom};
        idx <= 2'($urandom);
        @(posedge clk);
      end
      cv <= 0;
      repeat (3) @(posedge clk);
    end
    chk("left notes", q.size(), 0);
    apb(0, OFF_STATUS, 0);
    chk("status", rd[2:0], seen);
    chk("irq masked", irq, 0);
    apb(1, OFF_MASK, 32'h0000_0007);
    chk("irq", irq, seen != 0);
    apb(1, OFF_STATUS, {29'h0, seen});
    apb(0, OFF_STATUS, 0);
    chk("status clear", rd[2:0], 0);
    chk("irq clear", irq, 0);
    apb(0, 8'h40, 0);
    chk("unmapped", rd, 0);
    give_verdict();
  end
endmodule : test_access_dirty_flag_checker
`default_nettype wire
